// *** pwsc_defines.vh ***
`ifndef PWSC_DEFINES_VH
`define PWSC_DEFINES_VH

// Register offsets
`define PWSC_OFS_WDOG_CFG     8'h91
`define PWSC_OFS_GLBL_CTRL    8'h92
`define PWSC_OFS_ONOFF_ONE    8'h93

// Watchdog configuration register fields
`define PWSC_WD_TSEL_HI       1
`define PWSC_WD_TSEL_LO       0
`define PWSC_WD_ENABLE        2

// Sequencer and watchdog control register fields
`define PWSC_GC_SRC0          4
`define PWSC_GC_SOFT0         3
`define PWSC_GC_SRC1          2
`define PWSC_GC_SOFT1         1
`define PWSC_GC_WDCLR         0

// On/off control register fields
`define PWSC_OO_SOFT_RST      6
`define PWSC_OO_MRST_HI       5
`define PWSC_OO_MRST_LO       3
`define PWSC_OO_SLEEP         2
`define PWSC_OO_POWER_OFF     1
`define PWSC_OO_XDLY          0

// Reset values
`define PWSC_RST_WDOG_CFG     8'h00
`define PWSC_RST_GLBL_CTRL    8'h00
`define PWSC_RST_UNMAPPED     8'h00

// Timing: one second of system clock at 25 MHz
`define PWSC_CLK_HZ           25000000
`define PWSC_XDLY_S           1
`define PWSC_CYC_PER_SEC      (`PWSC_CLK_HZ * `PWSC_XDLY_S)

// Target address on the serial port
`define PWSC_I2C_ADDR         7'h3C

`endif

// *** pwsc_i2c_target.v ***
`timescale 1ns/10ps
`include "pwsc_defines.vh"

module pwsc_i2c_target
#(
    parameter [6:0] DEV_ADDR = `PWSC_I2C_ADDR
)
(
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe,
    output reg        wr_en,
    output reg  [7:0] wr_addr,
    output reg  [7:0] wr_data,
    output wire [7:0] rd_addr,
    input  wire [7:0] rd_data
);

    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_RECV = 5'b00010;
    localparam [4:0] ST_ACK  = 5'b00100;
    localparam [4:0] ST_SEND = 5'b01000;
    localparam [4:0] ST_MACK = 5'b10000;

    localparam [1:0] KIND_ADDR = 2'b00;
    localparam [1:0] KIND_PTR  = 2'b01;
    localparam [1:0] KIND_DATA = 2'b10;

    reg [2:0] scl_sync;
    reg [2:0] sda_sync;
    reg       scl_f;
    reg       sda_f;
    reg [4:0] state;
    reg [1:0] kind;
    reg       rw;
    reg       ack_on;
    reg       macked;
    reg [2:0] cnt;
    reg [7:0] shreg;
    reg [7:0] txreg;
    reg [7:0] ptr;

    wire [7:0] rx_byte = {shreg[6:0], sda_f};
    // Filtered levels only move when the last two stages agree
    wire scl_new  = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
    wire sda_new  = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
    wire scl_rise = scl_new & ~scl_f;
    wire scl_fall = ~scl_new & scl_f;
    wire start_c  = scl_f & scl_new & sda_f & ~sda_new;
    wire stop_c   = scl_f & scl_new & ~sda_f & sda_new;

    assign rd_addr = ptr;
    assign sda_out = 1'b0;
    assign sda_oe  = ((state == ST_ACK) & ack_on) | ((state == ST_SEND) & ~txreg[7]);

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            scl_sync <= 3'b111;
            sda_sync <= 3'b111;
            scl_f    <= 1'b1;
            sda_f    <= 1'b1;
            state    <= ST_IDLE;
            kind     <= KIND_ADDR;
            rw       <= 1'b0;
            ack_on   <= 1'b0;
            macked   <= 1'b0;
            cnt      <= 3'd0;
            shreg    <= 8'h00;
            txreg    <= 8'hFF;
            ptr      <= 8'h00;
            wr_en    <= 1'b0;
            wr_addr  <= 8'h00;
            wr_data  <= 8'h00;
        end
        else
        begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            scl_f    <= scl_new;
            sda_f    <= sda_new;
            wr_en    <= 1'b0;
            if (start_c)
            begin
                state  <= ST_RECV;
                kind   <= KIND_ADDR;
                cnt    <= 3'd0;
                ack_on <= 1'b0;
                txreg  <= 8'hFF;
            end
            else if (stop_c)
            begin
                state  <= ST_IDLE;
                ack_on <= 1'b0;
                txreg  <= 8'hFF;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                        state <= ST_IDLE;
                    ST_RECV:
                        if (scl_rise)
                        begin
                            shreg <= rx_byte;
                            cnt   <= cnt + 3'd1;
                            if (cnt == 3'd7)
                            begin
                                state <= ST_ACK;
                                if (kind == KIND_ADDR)
                                begin
                                    rw <= sda_f;
                                    if (rx_byte[7:1] != DEV_ADDR)
                                        state <= ST_IDLE;
                                end
                                else if (kind == KIND_PTR)
                                    ptr <= rx_byte;
                                else
                                begin
                                    wr_en   <= 1'b1;
                                    wr_addr <= ptr;
                                    wr_data <= rx_byte;
                                    ptr     <= ptr + 8'd1;
                                end
                            end
                        end
                    ST_ACK:
                        if (scl_fall)
                        begin
                            if (!ack_on)
                                ack_on <= 1'b1;
                            else
                            begin
                                ack_on <= 1'b0;
                                cnt    <= 3'd0;
                                if (kind == KIND_ADDR && rw)
                                begin
                                    state <= ST_SEND;
                                    txreg <= rd_data;
                                    ptr   <= ptr + 8'd1;
                                end
                                else
                                begin
                                    state <= ST_RECV;
                                    kind  <= (kind == KIND_ADDR) ? KIND_PTR : KIND_DATA;
                                end
                            end
                        end
                    ST_SEND:
                        if (scl_fall)
                        begin
                            cnt <= cnt + 3'd1;
                            if (cnt == 3'd7)
                            begin
                                state <= ST_MACK;
                                txreg <= 8'hFF;
                            end
                            else
                                txreg <= {txreg[6:0], 1'b1};
                        end
                    ST_MACK:
                        if (scl_rise)
                            macked <= ~sda_f;
                        else if (scl_fall)
                        begin
                            // A not-acknowledge ends the read; wait for stop
                            if (macked)
                            begin
                                state <= ST_SEND;
                                txreg <= rd_data;
                                ptr   <= ptr + 8'd1;
                                cnt   <= 3'd0;
                            end
                            else
                                state <= ST_IDLE;
                        end
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

endmodule

// *** pwsc_control.v ***
// Operation
// - Timeout codes 00..11 mean 2,16,64,128 s
// - Lock fuse 0: timeout writes always accepted
// - Lock fuse 1: timeout changes only when disabled
// - Sequencer 0 source: pin or soft bit
// - Sequencer 0 soft bit enables when selected
// - Sequencer 1 source: pin or soft bit
// - Sequencer 1 soft bit enables when selected
// - Writing clear bit one clears watchdog
// - Clear bit self-clears, reads zero
// - Reserved bits written zero, reads ignored
// - Soft reset: shutdown plus reset, wins, self-clears
// - Power off: shutdown without reset, then clears
// - Manual reset codes mean 2..12 s
// - Extra delay bit adds one second
`timescale 1ns/10ps
`include "pwsc_defines.vh"

module pwsc_control
#(
    parameter [31:0] CYC_PER_SEC = `PWSC_CYC_PER_SEC,
    parameter [6:0]  DEV_ADDR    = `PWSC_I2C_ADDR,
    parameter [2:0]  OTP_MANRST  = 3'b000,
    parameter        OTP_XDLY    = 1'b0
)
(
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe,
    input  wire       timeout_lock_fuse,
    input  wire       enable_zero_pin,
    input  wire       enable_one_pin,
    input  wire       shutdown_done,
    output wire       power_sequencer_zero,
    output wire       power_sequencer_one,
    output reg        watchdog_clear,
    output reg        watchdog_expired,
    output reg        power_down_request,
    output reg        reset_request,
    output reg        shutdown_active,
    output reg  [7:0] watchdog_timeout_seconds,
    output reg  [3:0] manual_reset_seconds,
    output reg        sleep_enable
);

    function [7:0] tsel_seconds;
        input [1:0] code;
        begin
            case (code)
                2'b00:   tsel_seconds = 8'd2;
                2'b01:   tsel_seconds = 8'd16;
                2'b10:   tsel_seconds = 8'd64;
                default: tsel_seconds = 8'd128;
            endcase
        end
    endfunction

    function [3:0] mrst_seconds;
        input [2:0] code;
        begin
            case (code)
                3'b000:  mrst_seconds = 4'd2;
                3'b001:  mrst_seconds = 4'd3;
                3'b010:  mrst_seconds = 4'd4;
                3'b011:  mrst_seconds = 4'd5;
                3'b100:  mrst_seconds = 4'd6;
                3'b101:  mrst_seconds = 4'd8;
                3'b110:  mrst_seconds = 4'd10;
                default: mrst_seconds = 4'd12;
            endcase
        end
    endfunction

    wire       wr_en;
    wire [7:0] wr_addr;
    wire [7:0] wr_data;
    wire [7:0] rd_addr;
    reg  [7:0] rd_data;

    reg  [1:0]  watchdog_timeout_select;
    reg         watchdog_enable_bit;
    reg         seq0_source_select;
    reg         seq0_soft_enable;
    reg         seq1_source_select;
    reg         seq1_soft_enable;
    reg         soft_reset_cmd;
    reg         power_off_cmd;
    reg  [2:0]  manual_reset_time;
    reg         enable_zero_extra_delay;
    reg         shutdown_with_reset;
    reg  [31:0] wd_prescale;
    reg  [7:0]  wd_seconds;
    reg  [31:0] ez_count;
    reg         ez_delayed;
    reg  [2:0]  pin_sync [0:1];
    reg  [1:0]  pin_f;

    wire wr_wdog = wr_en & (wr_addr == `PWSC_OFS_WDOG_CFG);
    wire wr_glbl = wr_en & (wr_addr == `PWSC_OFS_GLBL_CTRL);
    wire wr_onoff = wr_en & (wr_addr == `PWSC_OFS_ONOFF_ONE);
    wire [1:0] pins = {enable_one_pin, enable_zero_pin};

    pwsc_i2c_target #(.DEV_ADDR(DEV_ADDR)) u_port
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .sda_out (sda_out),
        .sda_oe  (sda_oe),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    // Reserved bits and the clear bit always read back zero
    always @*
    begin
        case (rd_addr)
            `PWSC_OFS_WDOG_CFG:
                rd_data = {5'b00000, watchdog_enable_bit, watchdog_timeout_select};
            `PWSC_OFS_GLBL_CTRL:
                rd_data = {3'b000, seq0_source_select, seq0_soft_enable,
                           seq1_source_select, seq1_soft_enable, 1'b0};
            `PWSC_OFS_ONOFF_ONE:
                rd_data = {1'b0, soft_reset_cmd, manual_reset_time, sleep_enable,
                           power_off_cmd, enable_zero_extra_delay};
            default:
                rd_data = `PWSC_RST_UNMAPPED;
        endcase
    end

    // Three-stage sampling of the enable pins
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_pin
            always @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    pin_sync[gi] <= 3'b000;
                    pin_f[gi]    <= 1'b0;
                end
                else
                begin
                    pin_sync[gi] <= {pin_sync[gi][1:0], pins[gi]};
                    if (pin_sync[gi][1] == pin_sync[gi][2])
                        pin_f[gi] <= pin_sync[gi][2];
                end
            end
        end
    endgenerate

    // Any shutdown in progress overrides both sequencer sources
    assign power_sequencer_zero = ~shutdown_active &
        (seq0_source_select ? seq0_soft_enable : ez_delayed);
    assign power_sequencer_one  = ~shutdown_active &
        (seq1_source_select ? seq1_soft_enable : pin_f[1]);

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            watchdog_timeout_select  <= 2'b00;
            watchdog_enable_bit      <= 1'b0;
            seq0_source_select       <= 1'b0;
            seq0_soft_enable         <= 1'b0;
            seq1_source_select       <= 1'b0;
            seq1_soft_enable         <= 1'b0;
            soft_reset_cmd           <= 1'b0;
            power_off_cmd            <= 1'b0;
            manual_reset_time        <= OTP_MANRST;
            sleep_enable             <= 1'b0;
            enable_zero_extra_delay  <= OTP_XDLY;
            shutdown_active          <= 1'b0;
            shutdown_with_reset      <= 1'b0;
            power_down_request       <= 1'b0;
            reset_request            <= 1'b0;
            watchdog_clear           <= 1'b0;
            watchdog_expired         <= 1'b0;
            wd_prescale              <= 32'h0000_0000;
            wd_seconds               <= 8'h00;
            ez_count                 <= 32'h0000_0000;
            ez_delayed               <= 1'b0;
            watchdog_timeout_seconds <= 8'd2;
            manual_reset_seconds     <= 4'd2;
        end
        else
        begin
            power_down_request       <= 1'b0;
            reset_request            <= 1'b0;
            watchdog_expired         <= 1'b0;
            watchdog_clear           <= wr_glbl & wr_data[`PWSC_GC_WDCLR];
            watchdog_timeout_seconds <= tsel_seconds(watchdog_timeout_select);
            manual_reset_seconds     <= mrst_seconds(manual_reset_time);

            if (wr_wdog)
            begin
                // Lock is judged against the enable held before this write
                if (!timeout_lock_fuse || !watchdog_enable_bit)
                    watchdog_timeout_select <= wr_data[`PWSC_WD_TSEL_HI:`PWSC_WD_TSEL_LO];
                watchdog_enable_bit <= wr_data[`PWSC_WD_ENABLE];
            end
            if (wr_glbl)
            begin
                seq0_source_select <= wr_data[`PWSC_GC_SRC0];
                seq0_soft_enable   <= wr_data[`PWSC_GC_SOFT0];
                seq1_source_select <= wr_data[`PWSC_GC_SRC1];
                seq1_soft_enable   <= wr_data[`PWSC_GC_SOFT1];
            end

            // A fresh command write wins over the end-of-shutdown clear
            if (wr_onoff)
            begin
                soft_reset_cmd          <= wr_data[`PWSC_OO_SOFT_RST] |
                                           (soft_reset_cmd & ~(shutdown_active & shutdown_done));
                power_off_cmd           <= wr_data[`PWSC_OO_POWER_OFF] |
                                           (power_off_cmd & ~(shutdown_active & shutdown_done));
                manual_reset_time       <= wr_data[`PWSC_OO_MRST_HI:`PWSC_OO_MRST_LO];
                sleep_enable            <= wr_data[`PWSC_OO_SLEEP];
                enable_zero_extra_delay <= wr_data[`PWSC_OO_XDLY];
            end
            else if (shutdown_active && shutdown_done)
            begin
                soft_reset_cmd <= 1'b0;
                power_off_cmd  <= 1'b0;
            end

            if (!shutdown_active && (soft_reset_cmd || power_off_cmd))
            begin
                shutdown_active     <= 1'b1;
                power_down_request  <= 1'b1;
                shutdown_with_reset <= soft_reset_cmd;
            end
            else if (shutdown_active && shutdown_done)
            begin
                shutdown_active <= 1'b0;
                reset_request   <= shutdown_with_reset | soft_reset_cmd;
            end

            // Counting in whole seconds keeps the timeout compare 8 bits wide
            if (!watchdog_enable_bit || watchdog_clear)
            begin
                wd_prescale <= 32'h0000_0000;
                wd_seconds  <= 8'h00;
            end
            else if (wd_prescale == CYC_PER_SEC - 32'd1)
            begin
                wd_prescale <= 32'h0000_0000;
                if (wd_seconds + 8'd1 == watchdog_timeout_seconds)
                begin
                    wd_seconds       <= 8'h00;
                    watchdog_expired <= 1'b1;
                end
                else
                    wd_seconds <= wd_seconds + 8'd1;
            end
            else
                wd_prescale <= wd_prescale + 32'd1;

            // Extra delay applies to both edges of the enable-0 level
            if (!enable_zero_extra_delay || pin_f[0] == ez_delayed)
            begin
                ez_count   <= 32'h0000_0000;
                ez_delayed <= pin_f[0];
            end
            else if (ez_count == CYC_PER_SEC - 32'd1)
            begin
                ez_count   <= 32'h0000_0000;
                ez_delayed <= pin_f[0];
            end
            else
                ez_count <= ez_count + 32'd1;
        end
    end

endmodule

// *** pwsc_control_asserts.sv ***
`timescale 1ns/10ps
module pwsc_control_asserts
(
    input wire       clk_sys,
    input wire       rst_n,
    input wire       shutdown_done,
    input wire       power_sequencer_zero,
    input wire       power_sequencer_one,
    input wire       watchdog_clear,
    input wire       watchdog_expired,
    input wire       power_down_request,
    input wire       reset_request,
    input wire       shutdown_active,
    input wire [7:0] watchdog_timeout_seconds,
    input wire [3:0] manual_reset_seconds
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_shut_start;
        !shutdown_active ##1 shutdown_active;
    endsequence
    sequence s_shut_stop;
        shutdown_active && shutdown_done;
    endsequence
    a_tsel_codes: assert property (watchdog_timeout_seconds inside {8'h02, 8'h10, 8'h40, 8'h80})
        else $error("bad timeout");
    a_mrst_codes: assert property (manual_reset_seconds inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC})
        else $error("bad manual reset time");
    a_pdr_start: assert property (s_shut_start |-> power_down_request)
        else $error("no power-down pulse");
    a_shut_stop: assert property (s_shut_stop |=> !shutdown_active)
        else $error("shutdown did not end");
    a_reset_end: assert property (reset_request |-> $fell(shutdown_active))
        else $error("stray reset request");
    a_seq_off: assert property (shutdown_active |-> !power_sequencer_zero && !power_sequencer_one)
        else $error("sequencer on in shutdown");
    a_clr_pulse: assert property (watchdog_clear |=> !watchdog_clear)
        else $error("clear stuck");
    a_clr_restart: assert property (watchdog_clear |=> !watchdog_expired [*8])
        else $error("expiry after clear");
endmodule

bind pwsc_control pwsc_control_asserts u_chk
(
    .clk_sys(clk_sys), .rst_n(rst_n), .shutdown_done(shutdown_done),
    .power_sequencer_zero(power_sequencer_zero), .power_sequencer_one(power_sequencer_one),
    .watchdog_clear(watchdog_clear), .watchdog_expired(watchdog_expired),
    .power_down_request(power_down_request), .reset_request(reset_request),
    .shutdown_active(shutdown_active), .watchdog_timeout_seconds(watchdog_timeout_seconds),
    .manual_reset_seconds(manual_reset_seconds)
);

// *** pwsc_host_model.sv ***
`timescale 1ns/10ps
module pwsc_host_model
#(
    parameter [6:0] DEV = 7'h3C
)
(
    input  wire clk_sys,
    input  wire sda_oe,
    output reg  scl,
    output wire sda
);
    reg sda_low;
    assign sda = ~(sda_low | sda_oe);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // One line changes per step, 8 clocks apart, so the input filter never sees a false start
    task step(input s, input d);
    begin
        repeat (8) @(negedge clk_sys);
        scl = s;
        sda_low = d;
    end
    endtask
    task byte_io(input [7:0] tx, input ab, output [7:0] rx, output ack);
        integer i;
        reg     r;
    begin
        for (i = 8; i >= 0; i = i - 1)
        begin
            step(1'b0, sda_low);
            step(1'b0, (i == 0) ? ~ab : ~tx[i - 1]);
            step(1'b1, sda_low);
            r = sda;
            if (i > 0)
                rx[i - 1] = r;
        end
        ack = ~r;
    end
    endtask
    task start;
    begin
        step(1'b0, sda_low);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    end
    endtask
    task stop;
    begin
        step(1'b0, sda_low);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    end
    endtask
    task wr(input [6:0] dev, input [7:0] ptr, input [7:0] dat, output ok);
        reg [7:0] d;
        reg       a, b, c;
    begin
        start;
        byte_io({dev, 1'b0}, 1'b1, d, a);
        byte_io(ptr, 1'b1, d, b);
        byte_io(dat, 1'b1, d, c);
        stop;
        ok = a & b & c;
    end
    endtask
    task rd(input [7:0] ptr, output [7:0] dat);
        reg [7:0] d;
        reg       a;
    begin
        start;
        byte_io({DEV, 1'b0}, 1'b1, d, a);
        byte_io(ptr, 1'b1, d, a);
        start;
        byte_io({DEV, 1'b1}, 1'b1, d, a);
        byte_io(8'hFF, 1'b1, dat, a);
        stop;
    end
    endtask
endmodule

// *** pwsc_control_test.sv ***
`timescale 1ns/10ps
module pwsc_control_test;
    localparam [31:0] CPS      = 32'h0000_01F4;
    localparam [31:0] TSEL_SEC = 32'h8040_1002;
    localparam [31:0] MRST_SEC = 32'hCA86_5432;
    reg        clk_sys, rst_n, fuse, pin0, pin1, sd_done, ok;
    reg  [7:0] rdv;
    wire       scl, sda, sda_oe, seq0, seq1, wd_clr, wd_exp, pdr, rst_req, sd_act, slp;
    wire [7:0] tsel_s;
    wire [3:0] mrst_s;
    integer    num_errors, num_checks, n_clr, n_exp, n_pdr, n_rst, since, gap, e, i;
    pwsc_control #(.CYC_PER_SEC(CPS)) u_dut
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .timeout_lock_fuse(fuse), .enable_zero_pin(pin0), .enable_one_pin(pin1), .shutdown_done(sd_done),
        .power_sequencer_zero(seq0), .power_sequencer_one(seq1), .watchdog_clear(wd_clr),
        .watchdog_expired(wd_exp), .power_down_request(pdr), .reset_request(rst_req),
        .shutdown_active(sd_act), .watchdog_timeout_seconds(tsel_s), .manual_reset_seconds(mrst_s),
        .sleep_enable(slp)
    );
    pwsc_host_model u_host (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        if (rst_n)
        begin
            since = wd_clr ? 0 : since + 1;
            if (wd_exp)
                gap = since;
            n_clr = n_clr + wd_clr;
            n_exp = n_exp + wd_exp;
            n_pdr = n_pdr + pdr;
            n_rst = n_rst + rst_req;
        end
    end
    task check(input [31:0] seen, input [31:0] exp, input [8*8-1:0] what);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("unexpected %0s: expected %0h, seen %0h", what, exp, seen);
        end
    end
    endtask
    task w(input [7:0] p, input [7:0] d);
        u_host.wr(7'h3C, p, d, ok);
    endtask
    task rdc(input [7:0] p, input [7:0] exp);
    begin
        u_host.rd(p, rdv);
        check(rdv, exp, "readback");
    end
    endtask
    task sd_end;
    begin
        sd_done = 1'b1;
        @(negedge clk_sys);
        sd_done = 1'b0;
        repeat (2) @(negedge clk_sys);
        check(sd_act, 0, "active");
    end
    endtask
    task t_timeout;
    begin
        check(tsel_s, 8'h02, "timeout");
        w(8'h91, 8'h04);
        for (i = 0; i < 4; i = i + 1)
        begin
            w(8'h92, 8'h01);
            w(8'h91, 8'h04 | i[7:0]);
            check(tsel_s, TSEL_SEC[i*8 +: 8], "timeout");
        end
        fuse = 1'b1;
        w(8'h91, 8'h04);
        check(tsel_s, 8'h80, "locked");
        w(8'h91, 8'h00);
        w(8'h92, 8'h01);
        w(8'h91, 8'h01);
        check(tsel_s, 8'h10, "unlocked");
        fuse = 1'b0;
        $display("timeout test done");
    end
    endtask
    task t_seq;
    begin
        for (i = 0; i < 16; i = i + 1)
        begin
            pin0 = ~i[2];
            pin1 = ~i[0];
            w(8'h92, {3'b000, i[3:0], 1'b0});
            check(seq0, i[3] ? i[2] : pin0, "seq0");
            check(seq1, i[1] ? i[0] : pin1, "seq1");
        end
        $display("sequencer test done");
    end
    endtask
    task t_clear;
    begin
        w(8'h92, 8'h01);
        w(8'h91, 8'h04);
        e = n_clr;
        w(8'h92, 8'h00);
        check(n_clr, e, "clears");
        w(8'h92, 8'h01);
        check(n_clr, e + 1, "clears");
        e = n_exp;
        w(8'h92, 8'h01);
        check(n_exp, e, "expiries");
        rdc(8'h92, 8'h00);
        repeat (40) @(negedge clk_sys);
        check(n_exp, e + 1, "expiries");
        check(gap + 2 >= 2 * CPS && gap <= 2 * CPS + 2, 1, "gap");
        $display("clear test done");
    end
    endtask
    task t_shut;
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            w(8'h93, {2'b00, i[2:0], 3'b000});
            check(mrst_s, MRST_SEC[i*4 +: 4], "man rst");
        end
        w(8'h92, 8'h1E);
        check(seq0 & seq1, 1, "seq on");
        e = n_rst;
        w(8'h93, 8'h02);
        check(seq0 | seq1, 0, "seq off");
        rdc(8'h93, 8'h02);
        sd_end;
        rdc(8'h93, 8'h00);
        check(n_rst, e, "resets");
        w(8'h93, 8'h42);
        sd_end;
        rdc(8'h93, 8'h00);
        check(n_rst, e + 1, "resets");
        check(n_pdr, 2, "downs");
        $display("shutdown test done");
    end
    endtask
    task t_misc;
    begin
        w(8'h93, 8'h05);
        check(slp, 1, "sleep");
        w(8'h92, 8'h00);
        pin0 = 1'b1;
        repeat (300) @(negedge clk_sys);
        check(seq0, 0, "delayed");
        repeat (300) @(negedge clk_sys);
        check(seq0, 1, "delayed");
        u_host.wr(7'h3D, 8'h92, 8'h1A, ok);
        check(ok, 0, "ack");
        rdc(8'h92, 8'h00);
        rdc(8'h95, 8'h00);
        $display("misc test done");
    end
    endtask
    task tally_and_finish;
    begin
        $display("checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    initial
    begin
        {rst_n, fuse, pin0, pin1, sd_done} = 5'h00;
        {num_errors, num_checks, n_clr, n_exp, n_pdr, n_rst, since, gap} = 0;
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_timeout;
        t_seq;
        t_clear;
        t_shut;
        t_misc;
        tally_and_finish;
    end
endmodule
